// *** design/oid_device.sv ***
// flash-side octal command decoder for id, status and register transactions
// Behaviour
// - 9f twice, zero address, returns identification bytes
// - 5a twice, address, returns table bytes sequentially
// - 4c twice, zero address, returns 64-bit serial
// - 05 twice, zero address, returns status one
// - 07 twice, zero address, returns status two
// - 65 twice, address, returns addressed register
// - 06 twice sets the write-enable latch
// - 04 twice clears the write-enable latch
// - 71 twice, address, one byte stored
// - register write only while latch is set
// - ddr: rising slot first, falling slot second
module oid_device (
  oid_link_if.dev link,
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ddr_mode,
  input wire logic [7:0] status_two,
  output logic write_latch,
  output logic reg_wr_stb,
  output logic [2:0] reg_wr_idx,
  output logic [7:0] reg_wr_data
);
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic ddr_s1;
    logic ddr_s2;
    logic [7:0] st2_s1;
    logic [7:0] st2_s2;
    oid_pkg::oid_dev_state_type state;
    logic [3:0] cnt;
    logic [31:0] sh;
    logic rise_v;
    logic [7:0] rise;
    logic [7:0] cmd;
    logic [31:0] addr;
    logic [2:0] idx;
    logic wel;
    logic [7:0][7:0] rf;
    logic wr_tgl;
    logic [2:0] wa;
    logic [7:0] wd;
    logic [7:0] dq_o;
    logic dq_oe;
  } oid_link_state_type;

  typedef struct packed {
    logic wel_s1;
    logic wel_s2;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic stb;
    logic [2:0] idx;
    logic [7:0] data;
  } oid_user_state_type;

  oid_link_state_type r_q;
  oid_link_state_type r_d;
  oid_user_state_type u_q;
  oid_user_state_type u_d;
  logic [7:0] fall_q;

  // byte i of the answer to a read command
  function automatic logic [7:0] pick(
    input logic [7:0] cmd,
    input logic [31:0] addr,
    input logic [2:0] i,
    input logic wel,
    input logic [7:0] st2,
    input logic [7:0][7:0] rf
  );
    logic [2:0] s;
    logic [7:0] sr1;
    s = addr[2:0] + i;
    sr1 = 8'h00;
    sr1[oid_pkg::SR1_WEL_BIT] = wel;
    case (cmd)
      oid_pkg::read_identification_cmd: pick = oid_pkg::ID_BYTES[{i[1:0], 3'h0} +: 8];
      oid_pkg::read_parameter_table_cmd: pick = oid_pkg::PARAM_TABLE[{s, 3'h0} +: 8];
      oid_pkg::read_serial_number_cmd: pick = oid_pkg::SERIAL_NUMBER[{i, 3'h0} +: 8];
      oid_pkg::read_status_one_cmd: pick = sr1;
      oid_pkg::read_status_two_cmd: pick = st2;
      oid_pkg::read_any_register_cmd: pick = rf[addr[2:0]];
      default: pick = 8'hff;
    endcase
  endfunction

  // falling-edge byte slot; only read one rising edge later
  always_ff @(negedge link.sck)
  begin
    fall_q <= link.dq;
  end

  always_comb
  begin
    logic [7:0] wdat;
    logic fixed_zero;
    r_d = r_q;
    wdat = 8'h00;
    fixed_zero = 1'b0;
    r_d.rst_s1 = rst_n;
    r_d.rst_s2 = r_q.rst_s1;
    r_d.ddr_s1 = ddr_mode;
    r_d.ddr_s2 = r_q.ddr_s1;
    r_d.st2_s1 = status_two;
    r_d.st2_s2 = r_q.st2_s1;
    if (!r_q.rst_s2)
    begin
      r_d.state = oid_pkg::DS_RECV;
      r_d.cnt = 4'h0;
      r_d.sh = 32'h0000_0000;
      r_d.rise_v = 1'b0;
      r_d.rise = 8'h00;
      r_d.cmd = 8'h00;
      r_d.addr = 32'h0000_0000;
      r_d.idx = 3'h0;
      r_d.wel = oid_pkg::WEL_RST;
      r_d.rf = {8{oid_pkg::REG_RST}};
      r_d.wr_tgl = 1'b0;
      r_d.wa = 3'h0;
      r_d.wd = 8'h00;
      r_d.dq_o = 8'h00;
      r_d.dq_oe = 1'b0;
    end
    else if (link.cs_n)
    begin
      // frame boundary: drop the bus and rearm the decoder
      r_d.state = oid_pkg::DS_RECV;
      r_d.cnt = 4'h0;
      r_d.rise_v = 1'b0;
      r_d.dq_oe = 1'b0;
    end
    else
    begin
      case (r_q.state)
        oid_pkg::DS_RECV:
        begin
          r_d.rise = link.dq;
          r_d.rise_v = 1'b1;
          if (!r_q.ddr_s2)
          begin
            r_d.sh = {r_q.sh[23:0], link.dq};
            r_d.cnt = r_q.cnt + 4'h1;
          end
          else if (r_q.rise_v)
          begin
            // pair completes only once its falling slot is in
            r_d.sh = {r_q.sh[15:0], r_q.rise, fall_q};
            r_d.cnt = r_q.cnt + 4'h2;
          end
          if (r_q.cnt < oid_pkg::CMD_END && r_d.cnt >= oid_pkg::CMD_END)
          begin
            r_d.cmd = r_d.sh[7:0];
            if (r_d.sh[15:8] != r_d.sh[7:0])
            begin
              r_d.state = oid_pkg::DS_SKIP;
            end
            else
            begin
              case (r_d.sh[7:0])
                oid_pkg::write_latch_set_cmd:
                begin
                  r_d.wel = 1'b1;
                  r_d.state = oid_pkg::DS_SKIP;
                end
                oid_pkg::write_latch_clear_cmd:
                begin
                  r_d.wel = 1'b0;
                  r_d.state = oid_pkg::DS_SKIP;
                end
                oid_pkg::read_identification_cmd,
                oid_pkg::read_parameter_table_cmd,
                oid_pkg::read_serial_number_cmd,
                oid_pkg::read_status_one_cmd,
                oid_pkg::read_status_two_cmd,
                oid_pkg::read_any_register_cmd,
                oid_pkg::write_any_register_cmd: r_d.state = oid_pkg::DS_RECV;
                default: r_d.state = oid_pkg::DS_SKIP;
              endcase
            end
          end
          if (r_q.cnt < oid_pkg::ADDR_END && r_d.cnt >= oid_pkg::ADDR_END)
          begin
            r_d.addr = r_d.sh;
            fixed_zero = r_q.cmd == oid_pkg::read_identification_cmd ||
                         r_q.cmd == oid_pkg::read_serial_number_cmd ||
                         r_q.cmd == oid_pkg::read_status_one_cmd ||
                         r_q.cmd == oid_pkg::read_status_two_cmd;
            if (r_q.cmd == oid_pkg::write_any_register_cmd)
            begin
              // no latch, no write: rest of the frame is ignored
              if (!r_q.wel)
              begin
                r_d.state = oid_pkg::DS_SKIP;
              end
            end
            else if (fixed_zero && r_d.sh != oid_pkg::ZERO_ADDR)
            begin
              r_d.state = oid_pkg::DS_SKIP;
            end
            else
            begin
              // no dummy cycles: first answer byte follows the address
              r_d.state = oid_pkg::DS_SEND;
              r_d.idx = 3'h0;
              r_d.dq_o = pick(r_q.cmd, r_d.sh, 3'h0, r_q.wel, r_q.st2_s2, r_q.rf);
              r_d.dq_oe = 1'b1;
            end
          end
          if (r_q.cnt < oid_pkg::DATA_END && r_d.cnt >= oid_pkg::DATA_END)
          begin
            // in ddr the data byte is the rising slot of its pair
            wdat = r_q.ddr_s2 ? r_d.sh[15:8] : r_d.sh[7:0];
            r_d.rf[r_q.addr[2:0]] = wdat;
            r_d.wa = r_q.addr[2:0];
            r_d.wd = wdat;
            r_d.wr_tgl = ~r_q.wr_tgl;
            r_d.state = oid_pkg::DS_SKIP;
          end
        end
        oid_pkg::DS_SEND:
        begin
          r_d.idx = r_q.idx + 3'h1;
          r_d.dq_o = pick(r_q.cmd, r_q.addr, r_q.idx + 3'h1, r_q.wel, r_q.st2_s2, r_q.rf);
        end
        oid_pkg::DS_SKIP:
        begin
          r_d.dq_oe = 1'b0;
        end
        default:
        begin
          r_d.state = oid_pkg::DS_SKIP;
          r_d.dq_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link.sck)
  begin
    r_q <= r_d;
  end

  // user side: latch state as a level, register writes as a toggle
  always_comb
  begin
    u_d = u_q;
    u_d.wel_s1 = r_q.wel;
    u_d.wel_s2 = u_q.wel_s1;
    u_d.tgl_s1 = r_q.wr_tgl;
    u_d.tgl_s2 = u_q.tgl_s1;
    u_d.tgl_s3 = u_q.tgl_s2;
    u_d.stb = u_q.tgl_s2 ^ u_q.tgl_s3;
    if (u_q.tgl_s2 ^ u_q.tgl_s3)
    begin
      // index and data changed with the toggle, so they are steady two flops later
      u_d.idx = r_q.wa;
      u_d.data = r_q.wd;
    end
    if (!rst_n)
    begin
      u_d = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    u_q <= u_d;
  end

  assign link.d_dq_o = r_q.dq_o;
  assign link.d_dq_oe = r_q.dq_oe;
  assign write_latch = u_q.wel_s2;
  assign reg_wr_stb = u_q.stb;
  assign reg_wr_idx = u_q.idx;
  assign reg_wr_data = u_q.data;
endmodule

// *** design/oid_host.sv ***
// host controller end: builds octal frames and collects answer bytes
module oid_host (
  oid_link_if.host link,
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_cmd,
  input wire logic [31:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic [3:0] req_len,
  input wire logic req_ddr,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic done
);
  typedef struct packed {
    oid_pkg::oid_host_state_type state;
    logic [1:0] ph;
    logic sck;
    logic cs_n;
    logic [7:0] dq_o;
    logic dq_oe;
    logic [4:0] cyc;
    logic [7:0] cmd;
    logic [31:0] addr;
    logic [7:0] data;
    logic [3:0] len;
    logic [3:0] ntx;
    logic [4:0] first;
    logic [4:0] last;
    logic ddr;
    logic [7:0] s1;
    logic [7:0] s2;
    logic ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic done;
    logic rst_run;
  } oid_host_reg_type;

  oid_host_reg_type r_q;
  oid_host_reg_type r_d;

  // byte for slot k: command twice, address msb first, then data
  function automatic logic [7:0] slot(
    input logic [7:0] cmd,
    input logic [31:0] addr,
    input logic [7:0] data,
    input logic [5:0] k
  );
    case (k)
      6'h0, 6'h1: slot = cmd;
      6'h2: slot = addr[31:24];
      6'h3: slot = addr[23:16];
      6'h4: slot = addr[15:8];
      6'h5: slot = addr[7:0];
      default: slot = data;
    endcase
  endfunction

  always_comb
  begin
    logic [3:0] ntx;
    logic [4:0] first;
    logic [5:0] k;
    r_d = r_q;
    ntx = oid_pkg::NTX_READ;
    first = 5'h0;
    k = 6'h0;
    r_d.s1 = link.dq;
    r_d.s2 = r_q.s1;
    r_d.rsp_valid = 1'b0;
    r_d.done = 1'b0;
    // sck is clk divided by four, high during RISE and HIGH
    r_d.ph = r_q.ph + 2'h1;
    r_d.sck = r_d.ph == oid_pkg::PH_RISE || r_d.ph == oid_pkg::PH_HIGH;
    case (r_q.state)
      oid_pkg::HS_IDLE:
      begin
        if (r_d.ph == oid_pkg::PH_SETUP && req_valid && r_q.ready)
        begin
          if (req_cmd == oid_pkg::write_latch_set_cmd || req_cmd == oid_pkg::write_latch_clear_cmd)
          begin
            ntx = oid_pkg::NTX_LATCH;
          end
          else if (req_cmd == oid_pkg::write_any_register_cmd)
          begin
            ntx = oid_pkg::NTX_WRITE;
          end
          // ddr pairs land one rising edge after their falling slot
          first = req_ddr ? 5'((ntx + 4'h1) >> 1) + 5'h1 : {1'b0, ntx};
          r_d.cmd = req_cmd;
          r_d.addr = req_addr;
          r_d.data = req_data;
          r_d.len = req_len;
          r_d.ddr = req_ddr;
          r_d.ntx = ntx;
          r_d.first = first;
          r_d.last = req_len == 4'h0 ? first : first + {1'b0, req_len} - 5'h1;
          r_d.cyc = 5'h0;
          r_d.cs_n = 1'b0;
          r_d.dq_o = slot(req_cmd, req_addr, req_data, 6'h0);
          r_d.dq_oe = 1'b1;
          r_d.ready = 1'b0;
          r_d.state = oid_pkg::HS_BUSY;
        end
      end
      oid_pkg::HS_BUSY:
      begin
        if (r_d.ph == oid_pkg::PH_RISE)
        begin
          r_d.cyc = r_q.cyc + 5'h1;
        end
        if (r_d.ph == oid_pkg::PH_HIGH)
        begin
          k = {r_q.cyc, 1'b0} - 6'h1;
          if (r_q.ddr && k < {2'h0, r_q.ntx})
          begin
            r_d.dq_o = slot(r_q.cmd, r_q.addr, r_q.data, k);
          end
          else if (r_q.ddr || r_q.cyc >= {1'b0, r_q.ntx})
          begin
            // release after the rising edge so the device can turn around
            r_d.dq_oe = 1'b0;
          end
        end
        if (r_d.ph == oid_pkg::PH_SETUP)
        begin
          if (r_q.len != 4'h0 && r_q.cyc >= r_q.first && r_q.cyc <= r_q.last)
          begin
            r_d.rsp_valid = 1'b1;
            r_d.rsp_data = r_q.s2;
          end
          k = r_q.ddr ? {r_q.cyc, 1'b0} : {1'b0, r_q.cyc};
          if (r_q.cyc == r_q.last)
          begin
            r_d.cs_n = 1'b1;
            r_d.dq_oe = 1'b0;
            r_d.done = 1'b1;
            r_d.ready = 1'b1;
            r_d.state = oid_pkg::HS_IDLE;
          end
          else if (k < {2'h0, r_q.ntx})
          begin
            r_d.dq_o = slot(r_q.cmd, r_q.addr, r_q.data, k);
            r_d.dq_oe = 1'b1;
          end
          else
          begin
            r_d.dq_oe = 1'b0;
          end
        end
      end
      default:
      begin
        r_d.state = oid_pkg::HS_IDLE;
      end
    endcase
    if (!rst_n)
    begin
      r_d = '0;
      r_d.state = oid_pkg::HS_IDLE;
      r_d.cs_n = 1'b1;
      r_d.ready = 1'b1;
      r_d.rst_run = 1'b1;
      r_d.ph = oid_pkg::PH_FALL;
      // sck keeps running in reset: the decoder's reset synchroniser needs its edges
      if (r_q.rst_run)
      begin
        r_d.ph = r_q.ph + 2'h1;
        r_d.sck = r_d.ph == oid_pkg::PH_RISE || r_d.ph == oid_pkg::PH_HIGH;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    r_q <= r_d;
  end

  assign link.sck = r_q.sck;
  assign link.cs_n = r_q.cs_n;
  assign link.h_dq_o = r_q.dq_o;
  assign link.h_dq_oe = r_q.dq_oe;
  assign req_ready = r_q.ready;
  assign rsp_valid = r_q.rsp_valid;
  assign rsp_data = r_q.rsp_data;
  assign done = r_q.done;
endmodule

// *** dv/octal_id_register_cmd_decoder_tb.sv ***
// self-checking bench: host and decoder joined over the octal link
module octal_id_register_cmd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [7:0] req_cmd = 8'h00;
  logic [31:0] req_addr = 32'h0;
  logic [7:0] req_data = 8'h00;
  logic [3:0] req_len = 4'h0;
  logic req_ddr = 1'b0;
  logic ddr_mode = 1'b0;
  logic [7:0] status_two = 8'h3c;
  logic req_ready, rsp_valid, done, write_latch, reg_wr_stb, drove, wel;
  logic [7:0] rsp_data, reg_wr_data, wr_dat;
  logic [2:0] reg_wr_idx, wr_idx;
  logic [7:0] rsp_q[$];
  logic [7:0] wire_q[$];
  logic [7:0] mdl[8];
  int n_mismatch = 0;
  int n_compared = 0;
  int n_wr = 0;

  oid_link_if link();
  oid_host oid_host_i (.link(link.host), .clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data),
    .req_len(req_len), .req_ddr(req_ddr), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .done(done));
  oid_device oid_device_i (.link(link.dev), .clk(clk), .rst_n(rst_n), .ddr_mode(ddr_mode),
    .status_two(status_two), .write_latch(write_latch), .reg_wr_stb(reg_wr_stb),
    .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data));
  oid_checker oid_checker_i (.clk(clk), .rst_n(rst_n), .sck(link.sck), .cs_n(link.cs_n),
    .h_dq_o(link.h_dq_o), .h_dq_oe(link.h_dq_oe), .d_dq_o(link.d_dq_o),
    .d_dq_oe(link.d_dq_oe), .dq(link.dq));

  always #10 clk = ~clk;

  always @(posedge link.sck)
    if (link.cs_n === 1'b0) wire_q.push_back(link.dq);
  always @(negedge link.sck)
    if (link.cs_n === 1'b0 && ddr_mode) wire_q.push_back(link.dq);
  always @(posedge clk)
    if (link.d_dq_oe === 1'b1 && link.cs_n === 1'b0) drove = 1'b1;
  // strobe and its payload settle at the rising edge, so look mid-cycle
  always @(negedge clk)
    if (reg_wr_stb === 1'b1)
    begin
      n_wr++;
      wr_idx = reg_wr_idx;
      wr_dat = reg_wr_data;
    end

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask

  function automatic logic [7:0] ans(input logic [7:0] c, input logic [31:0] a, input int i);
    case (c)
      oid_pkg::read_identification_cmd: return oid_pkg::ID_BYTES[8*(i%4)+:8];
      oid_pkg::read_serial_number_cmd: return oid_pkg::SERIAL_NUMBER[8*(i%8)+:8];
      oid_pkg::read_parameter_table_cmd:
        return oid_pkg::PARAM_TABLE[8*((int'(a[2:0])+i)%8)+:8];
      oid_pkg::read_status_one_cmd: return 8'(wel) << oid_pkg::SR1_WEL_BIT;
      oid_pkg::read_status_two_cmd: return status_two;
      default: return mdl[a[2:0]];
    endcase
  endfunction

  // one frame; ok low means the decoder must refuse and stay off the wire
  task automatic xfer(input logic [7:0] c, input logic [31:0] a, input logic [7:0] d,
    input logic [3:0] n, input logic dd, input logic ok);
    int k;
    int nt;
    logic [7:0] sl[7];
    sl = '{c, c, a[31:24], a[23:16], a[15:8], a[7:0], d};
    nt = (c == 8'h06 || c == 8'h04) ? 2 : (c == 8'h71 ? 7 : 6);
    if (dd !== ddr_mode)
    begin
      @(posedge clk);
      ddr_mode <= dd;
      repeat (16) @(posedge clk);
    end
    @(posedge clk);
    rsp_q.delete();
    wire_q.delete();
    drove = 1'b0;
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    req_data <= d;
    req_len <= n;
    req_ddr <= dd;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (req_ready !== 1'b0 && k < 10);
    for (k = 0; k < 300; k++)
    begin
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
      if (done === 1'b1) break;
    end
    chk1(done, 1'b1, "frame end");
    for (int i = 0; i < nt; i++)
      chk8(wire_q[i], sl[i], "wire slot");
    chk1(drove, ok && n != 4'h0, "device drive");
    if (ok)
      for (int i = 0; i < int'(n); i++)
        chk8(rsp_q[i], ans(c, a, i), "answer byte");
  endtask

  task automatic t_ident();
    xfer(oid_pkg::read_identification_cmd, 32'h0, 8'h00, 4'h6, 1'b0, 1'b1);
    xfer(oid_pkg::read_identification_cmd, 32'h0, 8'h00, 4'h5, 1'b1, 1'b1);
    xfer(oid_pkg::read_identification_cmd, 32'h0100, 8'h00, 4'h2, 1'b0, 1'b0);
    xfer(8'h3b, 32'h0, 8'h00, 4'h2, 1'b0, 1'b0);
    xfer(oid_pkg::read_serial_number_cmd, 32'h0, 8'h00, 4'h9, 1'b0, 1'b1);
    xfer(oid_pkg::read_serial_number_cmd, 32'h0, 8'h00, 4'h8, 1'b1, 1'b1);
    xfer(oid_pkg::read_parameter_table_cmd, 32'h0006, 8'h00, 4'h4, 1'b0, 1'b1);
    xfer(oid_pkg::read_parameter_table_cmd, 32'h0003, 8'h00, 4'h8, 1'b1, 1'b1);
    $display("done: identity reads");
  endtask

  task automatic t_latch();
    for (int m = 0; m < 2; m++)
    begin
      xfer(oid_pkg::write_latch_set_cmd, 32'h0, 8'h00, 4'h0, m[0], 1'b1);
      wel = 1'b1;
      repeat (6) @(posedge clk);
      chk1(write_latch, 1'b1, "latch set");
      xfer(oid_pkg::read_status_one_cmd, 32'h0, 8'h00, 4'h2, m[0], 1'b1);
      xfer(oid_pkg::write_latch_clear_cmd, 32'h0, 8'h00, 4'h0, m[0], 1'b1);
      wel = 1'b0;
      repeat (6) @(posedge clk);
      chk1(write_latch, 1'b0, "latch clear");
      xfer(oid_pkg::read_status_one_cmd, 32'h0, 8'h00, 4'h2, m[0], 1'b1);
      @(posedge clk);
      status_two <= m[0] ? 8'h5a : 8'hc3;
      repeat (8) @(posedge clk);
      xfer(oid_pkg::read_status_two_cmd, 32'h0, 8'h00, 4'h3, m[0], 1'b1);
    end
    $display("done: latch and status");
  endtask

  task automatic t_regs();
    n_wr = 0;
    xfer(oid_pkg::write_any_register_cmd, 32'h0002, 8'h5a, 4'h0, 1'b0, 1'b1);
    repeat (8) @(posedge clk);
    chk8(8'(n_wr), 8'h00, "write without latch");
    xfer(oid_pkg::read_any_register_cmd, 32'h0002, 8'h00, 4'h2, 1'b0, 1'b1);
    xfer(oid_pkg::write_latch_set_cmd, 32'h0, 8'h00, 4'h0, 1'b0, 1'b1);
    xfer(oid_pkg::write_any_register_cmd, 32'h0002, 8'hc3, 4'h0, 1'b0, 1'b1);
    repeat (8) @(posedge clk);
    mdl[2] = 8'hc3;
    chk8(8'(n_wr), 8'h01, "write count");
    chk8({5'h00, wr_idx}, 8'h02, "write index");
    chk8(wr_dat, 8'hc3, "write data");
    xfer(oid_pkg::write_any_register_cmd, 32'h0005, 8'h96, 4'h0, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    mdl[5] = 8'h96;
    chk8({5'h00, wr_idx}, 8'h05, "ddr write index");
    chk8(wr_dat, 8'h96, "ddr write data");
    xfer(oid_pkg::read_any_register_cmd, 32'h0002, 8'h00, 4'h2, 1'b1, 1'b1);
    xfer(oid_pkg::read_any_register_cmd, 32'h0005, 8'h00, 4'h2, 1'b0, 1'b1);
    $display("done: register access");
  endtask

  initial
  begin
    wel = 1'b0;
    for (int i = 0; i < 8; i++)
      mdl[i] = oid_pkg::REG_RST;
    // decoder reset passes through sck flops, so it is held longer than usual
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (16) @(posedge clk);
    chk1(write_latch, oid_pkg::WEL_RST, "latch after reset");
    t_ident();
    t_latch();
    t_regs();
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("BAD %0t: run hung", $time);
    test_done();
  end
endmodule

// *** dv/oid_checker.sv ***
// link-level assertions for the octal host and command decoder pair
module oid_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [7:0] h_dq_o,
  input wire logic h_dq_oe,
  input wire logic [7:0] d_dq_o,
  input wire logic d_dq_oe,
  input wire logic [7:0] dq
);
  logic [4:0] up_q;
  logic [4:0] up_d;
  logic armed;

  // device link reset crosses on sck, so its drive settles late
  assign armed = up_q[4];
  assign up_d = armed ? up_q : up_q + 5'h01;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      up_q <= 5'h00;
    else
      up_q <= up_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sck_low_half;
    !sck ##1 !sck;
  endsequence
  sequence sck_rest;
    sck ##1 sck_low_half ##1 sck;
  endsequence
  sequence idle_run;
    (armed && cs_n)[*6];
  endsequence
  property cmd_copies;
    logic [7:0] c;
    ($fell(cs_n), c = h_dq_o) |-> ##2 h_dq_o == c;
  endproperty

  sck_shape_a: assert property ($rose(sck) |-> ##1 sck_rest)
    else $error("link clock shape wrong");
  frame_start_a: assert property ($fell(cs_n) |-> h_dq_oe && !d_dq_oe && dq == h_dq_o)
    else $error("frame does not start with host driving");
  cmd_copy_a: assert property (cmd_copies)
    else $error("command copies differ");
  turn_around_a: assert property ($rose(d_dq_oe) |-> ##[0:2] !h_dq_oe)
    else $error("host still drives after device answers");
  answer_frame_a: assert property (armed && $rose(d_dq_oe) |-> !cs_n)
    else $error("device drives outside a frame");
  dev_release_a: assert property (armed && $rose(cs_n) |-> ##[0:6] !d_dq_oe)
    else $error("device keeps driving after frame");
  idle_quiet_a: assert property (idle_run |-> !d_dq_oe)
    else $error("device drives while idle");
  answer_hold_a: assert property (
    armed && d_dq_oe && $past(d_dq_oe) && $changed(d_dq_o) |-> $rose(sck))
    else $error("answer byte changed off rising clock");
  host_release_a: assert property ($rose(cs_n) |-> ##[0:4] !h_dq_oe)
    else $error("host drives after frame end");
endmodule

// *** include/oid_link_if.sv ***
// octal serial link between host controller and flash command decoder
interface oid_link_if;
  logic sck;
  logic cs_n;
  logic [7:0] h_dq_o;
  logic h_dq_oe;
  logic [7:0] d_dq_o;
  logic d_dq_oe;
  logic [7:0] dq;

  // weak pull-up when nobody drives; device wins a brief turnaround overlap
  assign dq = d_dq_oe ? d_dq_o : (h_dq_oe ? h_dq_o : 8'hff);

  modport host (
    output sck,
    output cs_n,
    output h_dq_o,
    output h_dq_oe,
    input dq
  );

  modport dev (
    input sck,
    input cs_n,
    input dq,
    output d_dq_o,
    output d_dq_oe
  );
endinterface

// *** include/oid_pkg.sv ***
// shared constants and types for the octal command decoder and its host
package oid_pkg;
  // command opcodes, each sent twice per transaction
  localparam logic [7:0] read_identification_cmd = 8'h9f;
  localparam logic [7:0] read_parameter_table_cmd = 8'h5a;
  localparam logic [7:0] read_serial_number_cmd = 8'h4c;
  localparam logic [7:0] read_status_one_cmd = 8'h05;
  localparam logic [7:0] read_status_two_cmd = 8'h07;
  localparam logic [7:0] read_any_register_cmd = 8'h65;
  localparam logic [7:0] write_latch_set_cmd = 8'h06;
  localparam logic [7:0] write_latch_clear_cmd = 8'h04;
  localparam logic [7:0] write_any_register_cmd = 8'h71;

  // byte-slot counts at which each part of a transaction is complete
  localparam logic [3:0] CMD_END = 4'h2;
  localparam logic [3:0] ADDR_END = 4'h6;
  localparam logic [3:0] DATA_END = 4'h7;
  localparam logic [3:0] NTX_LATCH = 4'h2;
  localparam logic [3:0] NTX_READ = 4'h6;
  localparam logic [3:0] NTX_WRITE = 4'h7;
  localparam logic [31:0] ZERO_ADDR = 32'h0000_0000;

  // status register one layout and reset values
  localparam int SR1_WEL_BIT = 1;
  localparam logic WEL_RST = 1'b0;
  localparam logic [7:0] REG_RST = 8'h00;

  // identity and table contents; values are arbitrary, low byte goes out first
  localparam logic [31:0] ID_BYTES = 32'h0055_aa5e;
  localparam logic [63:0] SERIAL_NUMBER = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] PARAM_TABLE = 64'hff00_0106_5044_4653;

  // host clock phases: sck high in RISE and HIGH, low in FALL and SETUP
  localparam logic [1:0] PH_RISE = 2'h0;
  localparam logic [1:0] PH_HIGH = 2'h1;
  localparam logic [1:0] PH_FALL = 2'h2;
  localparam logic [1:0] PH_SETUP = 2'h3;

  typedef enum logic [2:0] {
    DS_RECV = 3'h1,
    DS_SEND = 3'h2,
    DS_SKIP = 3'h4
  } oid_dev_state_type;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h1,
    HS_BUSY = 2'h2
  } oid_host_state_type;
endpackage
